// ---- bbm_pkg.sv ----
package bbm_pkg;
    localparam int PIX_W = 6;
    localparam int ADDR_W = 14;
    localparam int DITH_DEPTH = 64;
    localparam int DITH_AW = 6;
    localparam logic [3:0] PIX_PERIOD = 4'hF;
    localparam logic [3:0] SLOT_LAST_4 = 4'h3;
    localparam logic [3:0] SLOT_LAST_5 = 4'h4;
    localparam logic [3:0] SLOT_LAST_6 = 4'h5;
    localparam logic [3:0] SLOT_LAST_7 = 4'h6;
    localparam logic [13:0] WHITE_BASE = 14'h0000;
    localparam logic [13:0] CUR_BASE_64 = 14'h0A00;
    localparam logic [13:0] PREV_BASE_64 = 14'h1400;
    localparam logic [13:0] CUR_BASE_256 = 14'h2A00;
    localparam logic [13:0] PREV_BASE_256 = 14'h3400;
    localparam logic [13:0] ERR_BASE_256 = 14'h2000;
    localparam logic [13:0] ERR_BASE_64 = 14'h0000;
    localparam logic [5:0] PIX_MAX = 6'h3F;
    localparam logic [5:0] PIX_MID = 6'h20;
    localparam logic [4:0] RATIO_13_15_N = 5'h0D;
    localparam logic [4:0] RATIO_13_15_D = 5'h0F;
    localparam logic [4:0] RATIO_12_17_N = 5'h0C;
    localparam logic [4:0] RATIO_12_17_D = 5'h11;
    localparam logic [4:0] RATIO_9_11_N = 5'h09;
    localparam logic [4:0] RATIO_9_11_D = 5'h0B;
    localparam logic [4:0] RATIO_ONE = 5'h01;
    localparam logic [5:0] EDGE_LIMIT = 6'h10;

    typedef enum logic [1:0] {
        BBM_STYLE_SIMPLE = 2'h0,
        BBM_STYLE_DITHER = 2'h1,
        BBM_STYLE_ERROR = 2'h2,
        BBM_STYLE_SEPARATE = 2'h3
    } bbm_style_t;

    typedef enum logic [1:0] {
        BBM_RED_NONE = 2'h0,
        BBM_RED_A3_B4 = 2'h1,
        BBM_RED_A3_A4 = 2'h2,
        BBM_RED_B4_A4 = 2'h3
    } bbm_reduce_t;

    typedef enum logic [1:0] {
        BBM_IDLE = 2'h0,
        BBM_LINE = 2'h1,
        BBM_DONE = 2'h3
    } bbm_state_t;

    typedef struct packed {
        logic [5:0] level;
        logic line_start;
    } bbm_pix_t;

    typedef struct packed {
        logic [13:0] addr;
        logic we;
        logic cs_first;
        logic cs_second;
        logic [7:0] wdata;
    } bbm_mem_t;
endpackage

// ---- bbm_backend.sv ----
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
// Functional notes
// - Error diffusion runs only when the style field selects error diffusion.
// - Diffusion spreads each pixel's level-minus-result error onto neighbours.
// - Error diffusion also adds the shared dither threshold term.
// - Separation classifies text or gradation; text simple, gradation dithered.
// - Main-scan pixel skipping reduces at 13/15, 12/17 or 9/11.
// - Secondary mode bit picks motor-paced line drop or host-handled reduction.
// - With secondary reduction, dropped lines are read but not output.
// - Cut-out binarizes only a target-width window centred on the source line.
// - One pixel moves every 16 system clock periods.
// - Four to seven memory cycles per pixel period, by diffusion, dual chip, black correction.
// - Memory cycles serve correction data, current/previous lines, error buffer.
// - 64K map: white 0-097F, current 0A00-137F, previous 1400-1D7F.
// - 256K map: current 2A00, previous 3400, error 2000, white at 0.
// - Floating background threshold decides text pixels in simple and separation.
// - Dither thresholds come from an internal 64 by 6-bit store.
module bbm_backend
    import bbm_pkg::*;
#(
    parameter int LINE_PIX = 2432,
    parameter int CUT_PIX = 1728
) (
    input wire logic clk_sys, // System clock
    input wire logic reset, // Async reset
    input wire bbm_pix_t in_pix, // Corrected pixel
    input wire logic in_valid, // Pixel offered
    output logic in_ready, // Buffer can take pixel
    input wire logic [5:0] float_thr, // Background threshold
    input wire logic [5:0] grad_level, // Gradation measure
    input wire logic [5:0] grad_limit, // Text/gradation split
    input wire logic [1:0] style_sel, // Conversion style
    input wire logic [1:0] reduce_select, // Main scan ratio
    input wire logic target_width_select, // Cut-out enable
    input wire logic secondary_reduce_mode, // Line drop on
    input wire logic mem_256k, // 256K SRAM fitted
    input wire logic dual_chip, // Correction on first chip
    input wire logic black_corr, // Black correction used
    input wire logic dith_we, // Dither store write
    input wire logic [5:0] dith_wdata, // Dither write data
    input wire logic dith_addr_clr, // Dither address reset
    input wire logic [7:0] mem_rdata, // SRAM read data
    output bbm_mem_t mem_bus, // SRAM cycle
    output logic motor_step_timing, // Roller step pulse
    output logic out_bit, // Bi-level result
    output logic out_valid, // Result present
    input wire logic out_ready // Receiver ready
);
    initial begin
        if (LINE_PIX < 2 || LINE_PIX > 4096 || CUT_PIX > LINE_PIX) begin
            $error("bad line geometry");
        end
    end

    bbm_style_t style_q;
    bbm_state_t state_q, state_d;
    logic [3:0] phase_q;
    logic [11:0] pix_cnt_q;
    logic [4:0] skip_acc_q;
    logic [4:0] line_acc_q;
    logic line_drop_q;
    logic [5:0] dith_addr_q;
    logic [5:0] dith_mem [DITH_DEPTH];
    logic [7:0] err_carry_q;
    logic [7:0] err_mem_q;
    bbm_pix_t buf_q [2];
    logic [1:0] buf_cnt_q;
    logic buf_rd_q;
    logic buf_wr_q;
    logic res_q;
    logic res_v_q;
    bbm_mem_t mem_q;
    logic step_q;

    // Two-entry input buffer
    wire buf_full = buf_cnt_q == 2'h2;
    wire buf_empty = buf_cnt_q == 2'h0;
    wire take_in = in_valid && !buf_full;
    bbm_pix_t head;
    assign head = buf_q[buf_rd_q];

    wire pix_tick = phase_q == PIX_PERIOD;
    wire res_blocked = res_v_q && !out_ready;
    wire consume = pix_tick && !buf_empty && !res_blocked;
    wire new_line = consume && head.line_start;
    // a line's first pixel already uses the style for its line
    bbm_style_t style_cur;
    assign style_cur = head.line_start ? bbm_style_t'(style_sel) : style_q;

    logic [4:0] ratio_n, ratio_d;
    assign ratio_n = (reduce_select == BBM_RED_A3_B4) ? RATIO_13_15_N :
                     (reduce_select == BBM_RED_A3_A4) ? RATIO_12_17_N :
                     (reduce_select == BBM_RED_B4_A4) ? RATIO_9_11_N : RATIO_ONE;
    assign ratio_d = (reduce_select == BBM_RED_A3_B4) ? RATIO_13_15_D :
                     (reduce_select == BBM_RED_A3_A4) ? RATIO_12_17_D :
                     (reduce_select == BBM_RED_B4_A4) ? RATIO_9_11_D : RATIO_ONE;
    // keep a pixel when the accumulator carries
    wire [4:0] skip_base = head.line_start ? 5'h00 : skip_acc_q;
    wire [5:0] skip_sum = {1'b0, skip_base} + {1'b0, ratio_n};
    wire keep_pix = skip_sum >= {1'b0, ratio_d};
    wire [4:0] skip_next = keep_pix ? 5'(skip_sum - {1'b0, ratio_d}) : skip_sum[4:0];
    wire [5:0] line_sum = {1'b0, line_acc_q} + {1'b0, ratio_n};
    wire keep_line = line_sum >= {1'b0, ratio_d};
    wire [4:0] line_next = keep_line ? 5'(line_sum - {1'b0, ratio_d}) : line_sum[4:0];
    // the first pixel follows its own line's drop decision
    wire line_drop_now = head.line_start ? (secondary_reduce_mode && !keep_line)
                                         : line_drop_q;

    localparam logic [11:0] CUT_LO = 12'((LINE_PIX - CUT_PIX) / 2);
    localparam logic [11:0] CUT_HI = 12'((LINE_PIX - CUT_PIX) / 2 + CUT_PIX);
    wire [11:0] pos = head.line_start ? 12'h000 : pix_cnt_q;
    wire in_window = !target_width_select || (pos >= CUT_LO && pos < CUT_HI);

    wire [5:0] dith_thr = dith_mem[pos[5:0]];
    // incoming error from previous pixel and buffered line
    wire signed [8:0] err_in = $signed({err_carry_q[7], err_carry_q})
                             + $signed({err_mem_q[7], err_mem_q});
    wire signed [9:0] ed_sum = $signed({4'h0, head.level}) + 10'(err_in >>> 1)
                             + $signed({5'h00, dith_thr[5:1]}) - 10'sd16;
    wire ed_bit = ed_sum >= $signed({4'h0, PIX_MID});
    wire signed [9:0] ed_err = ed_sum - (ed_bit ? $signed({4'h0, PIX_MAX}) : 10'sd0);
    wire is_text = grad_level < grad_limit;

    logic bin_bit;
    always_comb begin
        unique case (style_cur)
            BBM_STYLE_SIMPLE: bin_bit = head.level < float_thr;
            BBM_STYLE_DITHER: bin_bit = head.level < dith_thr;
            // diffusion only in its style; dither added above
            BBM_STYLE_ERROR: bin_bit = !ed_bit;
            BBM_STYLE_SEPARATE: bin_bit = is_text ? head.level < float_thr
                                                  : head.level < dith_thr;
        endcase
    end

    // dropped lines still consumed but not emitted
    wire emit = consume && keep_pix && in_window && !line_drop_now;

    wire ed_on = style_cur == BBM_STYLE_ERROR;
    logic [3:0] slot_last;
    assign slot_last = (ed_on && black_corr) ? SLOT_LAST_7 :
                       (ed_on && dual_chip) ? SLOT_LAST_6 :
                       (ed_on || black_corr) ? SLOT_LAST_5 : SLOT_LAST_4;
    wire [13:0] cur_base = mem_256k ? CUR_BASE_256 : CUR_BASE_64;
    wire [13:0] prev_base = mem_256k ? PREV_BASE_256 : PREV_BASE_64;
    wire [13:0] err_base = mem_256k ? ERR_BASE_256 : ERR_BASE_64;
    wire [13:0] pa = 14'(pix_cnt_q);
    bbm_mem_t mem_d;
    always_comb begin
        mem_d = '0;
        if (phase_q <= slot_last) begin
            unique case (phase_q)
                4'h0: begin
                    mem_d.addr = WHITE_BASE + pa;
                    mem_d.cs_first = dual_chip;
                    mem_d.cs_second = !dual_chip;
                end
                4'h1: begin
                    mem_d.addr = prev_base + pa;
                    mem_d.cs_second = 1'b1;
                end
                4'h2: begin
                    mem_d.addr = cur_base + pa;
                    mem_d.we = 1'b1;
                    mem_d.wdata = {2'h0, head.level};
                    mem_d.cs_second = 1'b1;
                end
                4'h3: begin
                    mem_d.addr = ed_on ? err_base + pa : cur_base + pa;
                    mem_d.cs_second = 1'b1;
                end
                4'h4: begin
                    mem_d.addr = ed_on ? err_base + pa : WHITE_BASE + pa;
                    mem_d.we = ed_on;
                    mem_d.wdata = ed_err[7:0];
                    mem_d.cs_second = 1'b1;
                end
                default: begin
                    mem_d.addr = WHITE_BASE + pa;
                    mem_d.cs_first = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phase_q <= 4'h0;
            mem_q <= '0;
        end else begin
            phase_q <= phase_q + 4'h1;
            mem_q <= mem_d;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            buf_cnt_q <= 2'h0;
            buf_rd_q <= 1'b0;
            buf_wr_q <= 1'b0;
        end else begin
            if (take_in) begin
                buf_q[buf_wr_q] <= in_pix;
                buf_wr_q <= !buf_wr_q;
            end
            if (consume) begin
                buf_rd_q <= !buf_rd_q;
            end
            buf_cnt_q <= buf_cnt_q + 2'(take_in) - 2'(consume);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= BBM_IDLE;
            style_q <= BBM_STYLE_SIMPLE;
            pix_cnt_q <= 12'h000;
            skip_acc_q <= 5'h00;
            line_acc_q <= 5'h00;
            line_drop_q <= 1'b0;
            step_q <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= 1'b0;
            if (new_line) begin
                style_q <= bbm_style_t'(style_sel);
                // line drop only in secondary mode
                line_drop_q <= secondary_reduce_mode && !keep_line;
                line_acc_q <= line_next;
                step_q <= secondary_reduce_mode;
            end
            if (consume) begin
                pix_cnt_q <= pos + 12'h001;
                skip_acc_q <= skip_next;
            end
        end
    end

    always_comb begin
        unique case (state_q)
            BBM_IDLE: state_d = new_line ? BBM_LINE : BBM_IDLE;
            BBM_LINE: state_d = (consume && pos == 12'(LINE_PIX - 1)) ? BBM_DONE : BBM_LINE;
            BBM_DONE: state_d = new_line ? BBM_LINE : BBM_DONE;
            default: state_d = BBM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            err_carry_q <= 8'h00;
            err_mem_q <= 8'h00;
        end else begin
            // Slot 3 read data return two clocks after the slot
            if (phase_q == 4'h5) begin
                err_mem_q <= ed_on ? mem_rdata : 8'h00;
            end
            if (consume) begin
                err_carry_q <= (ed_on && !head.line_start) ? ed_err[7:0] : 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (dith_we) begin
            dith_mem[dith_addr_q] <= dith_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dith_addr_q <= 6'h00;
        end else if (dith_addr_clr) begin
            dith_addr_q <= 6'h00;
        end else if (dith_we) begin
            dith_addr_q <= dith_addr_q + 6'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            res_q <= 1'b0;
            res_v_q <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            in_ready <= buf_cnt_q + 2'(take_in) - 2'(consume) < 2'h2;
            if (emit) begin
                res_q <= bin_bit;
                res_v_q <= 1'b1;
            end else if (out_ready) begin
                res_v_q <= 1'b0;
            end
        end
    end

    assign out_bit = res_q;
    assign out_valid = res_v_q;
    assign mem_bus = mem_q;
    assign motor_step_timing = step_q;

    pix_period_a: assert property (@(posedge clk_sys) disable iff (reset)
        consume |-> ##16 (phase_q == PIX_PERIOD))
        else $error("pixel period not 16 clocks");
    line_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
        (consume && line_drop_q && !head.line_start) |=> !($rose(res_v_q)))
        else $error("dropped line produced output");
    motor_step_a: assert property (@(posedge clk_sys) disable iff (reset)
        (new_line && !secondary_reduce_mode) |=> !motor_step_timing)
        else $error("motor step without secondary reduction");
    white_slot_a: assert property (@(posedge clk_sys) disable iff (reset)
        (phase_q == 4'h0) |=> (mem_bus.addr == pa))
        else $error("white slot address wrong");
    cur_slot_a: assert property (@(posedge clk_sys) disable iff (reset)
        (phase_q == 4'h2 && mem_256k) |=> (mem_bus.addr == 14'(CUR_BASE_256 + $past(pa))))
        else $error("current line address wrong");
    slot_count_a: assert property (@(posedge clk_sys) disable iff (reset)
        (phase_q > SLOT_LAST_7) |=> (mem_bus == '0))
        else $error("memory cycle past slot seven");
    style_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        !new_line |=> $stable(style_q))
        else $error("style changed mid line");
    // error buffer written only in diffusion
    err_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (phase_q == 4'h4 && !ed_on) |=> !mem_bus.we)
        else $error("error buffer written outside diffusion");
endmodule

// ---- bbm_sram_model.sv ----
`timescale 1ns/100ps
module bbm_sram_model
    import bbm_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire bbm_mem_t mem_bus, // Cycle from block
    output logic [7:0] mem_rdata // Read data
);
    logic [7:0] mem_q [0:16383];
    wire sel = mem_bus.cs_first | mem_bus.cs_second;
    initial begin
        mem_rdata = 8'h00;
        for (int i = 0; i < 16384; i++) begin
            mem_q[i] = 8'h00;
        end
    end
    always @(posedge clk_sys) begin
        if (sel && mem_bus.we) begin
            mem_q[mem_bus.addr] <= mem_bus.wdata;
        end
        // Bus released: never hold last value
        mem_rdata <= (sel && !mem_bus.we) ? mem_q[mem_bus.addr] : ~mem_rdata;
    end
endmodule

// ---- test_bbm_backend.sv ----
`timescale 1ns/100ps
module test_bbm_backend;
    import bbm_pkg::*;
    localparam int LP = 32;
    localparam int CP = 16;
    logic clk_sys = 0, reset = 1, in_valid = 0, in_ready, out_bit, out_valid, out_ready = 1;
    bbm_pix_t in_pix = '0;
    logic [5:0] float_thr = 6'h20, grad_level = 6'h00, grad_limit = 6'h3F, dith_wdata = 6'h00;
    logic [1:0] style_sel = 2'h0, reduce_select = 2'h0;
    logic target_width_select = 0, secondary_reduce_mode = 0, mem_256k = 0, dual_chip = 0;
    logic black_corr = 0, dith_we = 0, dith_addr_clr = 0, motor_step_timing, rdy_s = 0;
    logic [7:0] mem_rdata;
    bbm_mem_t mem_bus;
    int seed = 82157, failures = 0, n_tests = 0, cyc = 0, last_cyc = 0, n_out = 0, n_mem = 0;
    int n_step = 0, n_err_wr = 0, lo, hi, m0, s0, o0;
    bit use_model = 0, per_chk = 0, rnd_rdy = 0, stall = 0, dth = 0, big_s = 0;
    logic exp_q [$];
    bbm_backend #(.LINE_PIX(LP), .CUT_PIX(CP)) bbm_backend_i (.clk_sys(clk_sys), .reset(reset),
        .in_pix(in_pix), .in_valid(in_valid), .in_ready(in_ready), .float_thr(float_thr),
        .grad_level(grad_level), .grad_limit(grad_limit), .style_sel(style_sel),
        .reduce_select(reduce_select), .target_width_select(target_width_select),
        .secondary_reduce_mode(secondary_reduce_mode), .mem_256k(mem_256k),
        .dual_chip(dual_chip), .black_corr(black_corr), .dith_we(dith_we),
        .dith_wdata(dith_wdata), .dith_addr_clr(dith_addr_clr), .mem_rdata(mem_rdata),
        .mem_bus(mem_bus), .motor_step_timing(motor_step_timing), .out_bit(out_bit),
        .out_valid(out_valid), .out_ready(out_ready));
    bbm_sram_model bbm_sram_model_i (.clk_sys(clk_sys), .mem_bus(mem_bus),
        .mem_rdata(mem_rdata));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic bit addr_ok(logic [13:0] a, logic big);
        if (a <= 14'h097F || (a >= 14'h0A00 && a <= 14'h137F)) return 1;
        if (!big) return a >= 14'h1400 && a <= 14'h1D7F;
        return (a >= 14'h2000 && a <= 14'h297F) || (a >= 14'h2A00 && a <= 14'h337F) ||
            (a >= 14'h3400 && a <= 14'h3D7F);
    endfunction
    // Receiver stalls at random or holds off entirely
    always @(posedge clk_sys) begin
        out_ready <= stall ? 1'b0 : (rnd_rdy ? 1'($random(seed)) : 1'b1);
    end
    // Motor step output only observed, never fed back
    always @(negedge clk_sys) begin
        cyc++;
        rdy_s = in_ready;
        if (motor_step_timing === 1'b1) n_step++;
        if (mem_bus.cs_first === 1'b1 || mem_bus.cs_second === 1'b1) begin
            n_mem++;
            check("mem addr", addr_ok(mem_bus.addr, big_s), 1);
            if (mem_bus.we && big_s && mem_bus.addr >= 14'h2000 && mem_bus.addr <= 14'h297F)
                n_err_wr++;
        end
        // Bus cycle was set up with the previous cycle's memory size
        big_s = mem_256k;
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            if (per_chk && n_out > 0) check("pixel period", cyc - last_cyc, 16);
            last_cyc = cyc;
            n_out++;
            if (use_model) begin
                if (exp_q.size() == 0) check("extra output", 1, 0);
                else check("out bit", out_bit, exp_q.pop_front());
            end
        end
    end
    task automatic run_line(input bit cut, input bit sw);
        logic [5:0] lv;
        int k;
        for (int p = 0; p < LP; p++) begin
            lv = 6'($random(seed));
            if (use_model && (!cut || (p >= (LP - CP) / 2 && p < (LP + CP) / 2)))
                exp_q.push_back(dth ? lv < 6'(p * 5) : lv < float_thr);
            in_pix <= '{level: lv, line_start: (p == 0)};
            in_valid <= 1;
            if (sw && p == 5) style_sel <= BBM_STYLE_ERROR;
            for (k = 0; k < 400; k++) begin
                @(posedge clk_sys);
                if (rdy_s) break;
            end
            if (k == 400) begin
                failures++;
                final_report();
            end
        end
        in_valid <= 0;
        repeat (80) @(posedge clk_sys);
    endtask
    task automatic cfg(input logic [1:0] st, input logic [1:0] rd, input logic big,
        input logic du, input logic bk);
        @(posedge clk_sys);
        style_sel <= st;
        reduce_select <= rd;
        mem_256k <= big;
        dual_chip <= du;
        black_corr <= bk;
        float_thr <= 6'($random(seed));
        @(posedge clk_sys);
    endtask
    initial begin
        logic [4:0] nn [4] = '{RATIO_ONE, RATIO_13_15_N, RATIO_12_17_N, RATIO_9_11_N};
        logic [4:0] dd [4] = '{RATIO_ONE, RATIO_13_15_D, RATIO_12_17_D, RATIO_9_11_D};
        int slots [4] = '{4, 5, 6, 7};
        repeat (5) @(posedge clk_sys);
        reset <= 0;
        repeat (2) @(posedge clk_sys);
        dith_addr_clr <= 1;
        @(posedge clk_sys);
        dith_addr_clr <= 0;
        for (int i = 0; i < DITH_DEPTH; i++) begin
            dith_we <= 1;
            dith_wdata <= 6'(i * 5);
            @(posedge clk_sys);
        end
        dith_we <= 0;
        use_model = 1;
        per_chk = 1;
        cfg(BBM_STYLE_SIMPLE, BBM_RED_NONE, 0, 0, 0);
        run_line(0, 0);
        per_chk = 0;
        rnd_rdy = 1;
        cfg(BBM_STYLE_SEPARATE, BBM_RED_NONE, 0, 0, 0);
        run_line(0, 0);
        cfg(BBM_STYLE_SIMPLE, BBM_RED_NONE, 0, 0, 0);
        target_width_select <= 1;
        o0 = n_out;
        run_line(1, 0);
        check("cut count", n_out - o0, CP);
        target_width_select <= 0;
        run_line(0, 1);
        use_model = 0;
        run_line(0, 0);
        check("model drained", exp_q.size(), 0);
        // Unreduced dither line checked against the written store
        dth = 1;
        for (int r = 0; r < 4; r++) begin
            use_model = (r == 0);
            cfg(BBM_STYLE_DITHER, 2'(r), 0, 0, 0);
            o0 = n_out;
            run_line(0, 0);
            lo = LP * nn[r] / dd[r];
            hi = (r == 0) ? lo : lo + 1;
            check("kept pixels", (n_out - o0 >= lo) && (n_out - o0 <= hi), 1);
        end
        dth = 0;
        for (int c = 0; c < 4; c++) begin
            cfg(c >= 2 ? BBM_STYLE_ERROR : BBM_STYLE_SIMPLE, BBM_RED_NONE, c == 3, c == 2,
                c == 1 || c == 3);
            fork
                run_line(0, 0);
                begin
                    repeat (48) @(posedge clk_sys);
                    m0 = n_mem;
                    repeat (64) @(posedge clk_sys);
                    check("mem cycles", n_mem - m0, slots[c] * 4);
                end
            join
        end
        check("error writes", n_err_wr > 0, 1);
        for (int s = 0; s < 2; s++) begin
            cfg(BBM_STYLE_SIMPLE, BBM_RED_B4_A4, 0, 0, 0);
            secondary_reduce_mode <= s;
            s0 = n_step;
            o0 = n_out;
            repeat (6) run_line(0, 0);
            if (s == 0) begin
                check("no step", n_step - s0, 0);
                lo = n_out - o0;
            end else begin
                check("step seen", n_step > s0, 1);
                check("lines dropped", n_out - o0 < lo, 1);
            end
        end
        secondary_reduce_mode <= 0;
        cfg(BBM_STYLE_SIMPLE, BBM_RED_NONE, 0, 0, 0);
        use_model = 1;
        stall <= 1;
        fork
            run_line(0, 0);
            begin
                repeat (120) @(posedge clk_sys);
                check("buffer full", rdy_s, 0);
                stall <= 0;
            end
        join
        check("no loss", exp_q.size(), 0);
        final_report();
    end
endmodule
